/* File: dbs_pkg.sv */
// Package for the two-beat double-rate common-I/O memory model.
// Assumes one core clock that samples both input clocks as plain pins.
package dbs_pkg;
    localparam int ADDR_W_DEF    = 8;
    localparam int LANES_DEF     = 2;
    localparam int LANE_W        = 9;
    localparam int BURST_LEN     = 2;    // fixed burst of two beats
    localparam int LAT_HALVES    = 5;    // 2.5 cycles, in half cycles
    localparam int LAT_HALVES_DL = 2;    // 1.0 cycle with the loop bypassed
    localparam logic [2:0] CNT_RST = 3'h0;

    // One command captured on a true-clock rising edge
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } dbs_cmd_t;

    // Link clock edge events found by the core clock
    typedef struct packed {
        logic k_rise;
        logic kn_rise;
    } dbs_edges_t;
endpackage : dbs_pkg

/* File: dbs_sram.sv */
// Two-beat double-rate common-I/O memory, device side.
// Assumes the input clocks run well below core_clk / 4 so that the
// core clock finds every edge after synchronising; data pins are
// sampled through the same two-flop chain so they stay aligned.
// Overview of operation
// [RULE1] A true-clock rising edge starts each operation; the array access then completes by itself.
// [RULE2] Addresses are taken on true-clock rising edges for the operation being issued.
// [RULE3] Every read and write moves exactly two beats.
// [RULE4] The true-clock edge captures address, controls, masks and first write beat.
// [RULE5] The complementary-clock edge captures masks and the second write beat.
// [RULE6] Only bytes whose mask is active in a beat are written.
// [RULE7] The controller gives the first write beat one cycle after the command, the second on the next complementary edge.
// [RULE8] The first read beat is driven from the third complementary edge, 2.5 cycles after the command.
// [RULE9] The second read beat is driven on the fourth true-clock edge counting the command edge as first.
// [RULE10] Echo clocks toggle together with the read data.
// [RULE11] With the loop bypassed the read latency is one cycle.
// [RULE12] A valid flag marks read data cycles, aligned with the echo clocks.
// [RULE13] A read of an address still in the write buffer returns the new bytes.
// [RULE14] A low load select on a true edge issues an operation, direction high for read.
module dbs_sram
    import dbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Link clocks and controls
    input  wire logic                    in_clk,
    input  wire logic                    in_clk_inv,
    input  wire logic                    operation_select_n,
    input  wire logic                    read_select,
    input  wire logic                    loop_bypass_n,
    input  wire logic [ADDR_W-1:0]       word_location_inputs,
    input  wire logic [LANES-1:0]        lane_write_mask_n,
    // Shared data lines, split
    input  wire logic [LANES*LANE_W-1:0] shared_io_lines_in,
    output logic      [LANES*LANE_W-1:0] shared_io_lines_out,
    output logic                         shared_io_lines_oe_n,
    // Echo clocks and valid flag
    output logic                         echo_timing_out,
    output logic                         echo_timing_out_inv,
    output logic                         output_valid_flag
);
    localparam int DW = LANES*LANE_W;
    localparam int SW = 4 + ADDR_W + LANES + DW;

    // Two-flop synchronisers for every link input
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [1:0]    clk_prev;
    wire  [SW-1:0] raw_in = {in_clk, in_clk_inv, operation_select_n,
                             read_select, word_location_inputs,
                             lane_write_mask_n, shared_io_lines_in};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1    <= '0;
            sync2    <= '0;
            clk_prev <= 2'h0;
        end else begin
            sync1    <= raw_in;
            sync2    <= sync1;
            clk_prev <= sync2[SW-1 -: 2];
        end
    end

    // Decoded, synchronised fields
    wire              s_k     = sync2[SW-1];
    wire              s_kn    = sync2[SW-2];
    wire              s_ld_n  = sync2[SW-3];
    wire              s_rd    = sync2[SW-4];
    wire [ADDR_W-1:0] s_addr  = sync2[DW+LANES +: ADDR_W];
    wire [LANES-1:0]  s_mask  = ~sync2[DW +: LANES];
    wire [DW-1:0]     s_data  = sync2[DW-1:0];
    // Edge finder: clk_prev resets low, so a true clock that idles low
    // gives no false edge after reset. The complement idles high; a
    // single false rise there only rewrites the idle drive, valid and echo levels, harmless.
    dbs_edges_t       edg;
    assign edg.k_rise  = s_k & ~clk_prev[1];
    assign edg.kn_rise = s_kn & ~clk_prev[0];

    // Loop bypass pin is static; its own small synchroniser
    logic [1:0] byp_sync;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) byp_sync <= 2'h0;
        else        byp_sync <= {byp_sync[0], ~loop_bypass_n};
    end
    wire dll_off = byp_sync[1]; // RULE11

    // Memory array: every burst address owns an even and an odd word,
    // so the array is twice as deep as the address space.
    logic [DW-1:0] mem [0:(2<<ADDR_W)-1];

    // Late-write buffer: address, pending flag, beat progress
    logic [ADDR_W-1:0] wr_addr;
    logic [1:0]        wr_stage;    // 0 idle, 1 wait beat0, 2 wait beat1
    logic [DW-1:0]     wbuf [0:1];
    logic [LANES-1:0]  wbuf_m [0:1];

    // Word pair of the pending write: even word first, odd word second.
    // Built by concatenation so no index arithmetic can overflow.
    wire [ADDR_W:0] wr_even = {wr_addr, 1'b0};      // RULE3
    wire [ADDR_W:0] wr_odd  = {wr_addr, 1'b1};

    wire issue   = edg.k_rise & ~s_ld_n;        // RULE1 RULE14
    wire is_rd   = issue & s_rd;
    wire is_wr   = issue & ~s_rd;

    // Byte-masked merge of a beat into a word
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
        input logic [DW-1:0] nw, input logic [LANES-1:0] m);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < LANES; i++)
            if (m[i]) r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
        return r;
    endfunction

    // Write path: command on true edge, beats on following edges
    always_ff @(posedge core_clk) begin
        if (wr_stage == 2'h2 && edg.kn_rise) begin
            mem[wr_even] <= merge(mem[wr_even], wbuf[0],
                                  wbuf_m[0]);               // RULE6
            mem[wr_odd]  <= merge(mem[wr_odd], s_data,
                                  s_mask);                  // RULE3 RULE5
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_stage  <= 2'h0;
            wr_addr   <= '0;
            wbuf[0]   <= '0;
            wbuf[1]   <= '0;
            wbuf_m[0] <= '0;
            wbuf_m[1] <= '0;
        end else begin
            if (wr_stage == 2'h1 && edg.k_rise) begin
                wbuf[0]   <= s_data;                        // RULE4 RULE7
                wbuf_m[0] <= s_mask;
                wr_stage  <= 2'h2;
            end else if (wr_stage == 2'h2 && edg.kn_rise) begin
                wbuf[1]   <= s_data;
                wbuf_m[1] <= s_mask;
                wr_stage  <= 2'h0;
            end
            if (is_wr) begin
                wr_addr  <= s_addr;                         // RULE2
                wr_stage <= 2'h1;
            end
        end
    end

    // Read path: capture address, count half-cycle clock edges
    logic [ADDR_W-1:0] rd_addr;
    logic [2:0]        rd_cnt;
    logic              rd_busy;
    // Word pair of the read burst, same pairing as the write side
    wire [ADDR_W:0]    rd_even = {rd_addr, 1'b0};
    wire [ADDR_W:0]    rd_odd  = {rd_addr, 1'b1};
    // Both beats are read from the array when they are driven, not at
    // the command; a write landing in between is therefore seen.
    wire  any_edge = edg.k_rise | edg.kn_rise;
    wire [2:0] lat = dll_off ? 3'(LAT_HALVES_DL) : 3'(LAT_HALVES);
    // Coherency: buffered write bytes overlay array data only once the write has landed (wr_stage 0)
    wire hit_wbuf  = (rd_addr == wr_addr) && (wr_stage == 2'h0);
    wire [DW-1:0] beat0 = hit_wbuf ?
        merge(mem[rd_even], wbuf[0], wbuf_m[0]) : mem[rd_even];
    wire [DW-1:0] beat1 = hit_wbuf ?
        merge(mem[rd_odd], wbuf[1], wbuf_m[1]) : mem[rd_odd];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr <= '0;
            rd_cnt  <= CNT_RST;
            rd_busy <= 1'b0;
        end else if (is_rd) begin
            rd_addr <= s_addr;                              // RULE2 RULE4
            rd_cnt  <= CNT_RST;
            rd_busy <= 1'b1;
        end else if (rd_busy && any_edge) begin
            rd_cnt <= rd_cnt + 3'h1;
            if (rd_cnt == lat) rd_busy <= 1'b0;             // RULE3
        end
    end

    // Output drive: beat0 at latency, beat1 one half cycle later.
    // Normal latency puts beat0 on a complement edge and beat1 on a
    // true edge; with the loop bypassed the order of edges swaps.
    // A controller must use the echo clocks, not a fixed edge, to
    // pick up the beats.
    wire drive0 = rd_busy && any_edge && (rd_cnt + 3'h1 == lat);
    wire drive1 = rd_busy && any_edge && (rd_cnt == lat);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shared_io_lines_out  <= '0;
            shared_io_lines_oe_n <= 1'b1;
            output_valid_flag    <= 1'b0;
        end else if (drive0) begin
            shared_io_lines_out  <= beat0;                  // RULE8 RULE13
            shared_io_lines_oe_n <= 1'b0;
            output_valid_flag    <= 1'b1;                   // RULE12
        end else if (drive1) begin
            shared_io_lines_out  <= beat1;                  // RULE9 RULE13
        end else if (any_edge) begin
            shared_io_lines_oe_n <= 1'b1;
            output_valid_flag    <= 1'b0;                   // RULE12
        end
    end

    // Echo clocks follow the input clocks, so they change with the data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_timing_out     <= 1'b0;
            echo_timing_out_inv <= 1'b1;
        end else if (any_edge) begin
            echo_timing_out     <= edg.k_rise;              // RULE10
            echo_timing_out_inv <= edg.kn_rise;             // RULE10
        end
    end
endmodule // dbs_sram

/* File: dbs_sram_sva.sv */
// Checker: read latency, echo clocks and valid flag of the memory.
// Assumes link clocks idle with the true clock low; checks both bypass settings.
module dbs_sram_sva import dbs_pkg::*; (
    // Clock, reset and link inputs
    input wire logic core_clk, rst_n, in_clk, in_clk_inv,
    input wire logic loop_bypass_n,
    input wire logic operation_select_n, read_select,
    // Memory outputs
    input wire logic shared_io_lines_oe_n, echo_timing_out,
    input wire logic echo_timing_out_inv, output_valid_flag
);
    logic       k_q, kn_q, rd_last;
    logic [2:0] halves;
    wire        k_rise = in_clk & ~k_q;
    wire        issue  = k_rise & ~operation_select_n;
    wire        half   = k_rise | (in_clk_inv & ~kn_q);
    // Half edges since the last command; saturates so idle time is safe
    wire [2:0]  next_halves = issue ? 3'h0
                            : halves + {2'h0, half && halves != 3'h7};
    wire        next_rd = issue ? read_select : rd_last;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {k_q, kn_q, rd_last, halves} <= 6'h17;
        end else begin
            {k_q, kn_q, rd_last, halves} <=
                {in_clk, in_clk_inv, next_rd, next_halves};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_FIRST: assert property ($rose(output_valid_flag)
        |-> halves == (loop_bypass_n ? 3'h5 : 3'h2))
        else $error("first beat misplaced");
    AST_SECOND: assert property (($rose(echo_timing_out)
        || $rose(echo_timing_out_inv)) && output_valid_flag
        && !$rose(output_valid_flag)
        |-> halves == (loop_bypass_n ? 3'h6 : 3'h3)) else $error("second beat");
    AST_SPAN: assert property (output_valid_flag
        |-> rd_last && halves >= (loop_bypass_n ? 3'h5 : 3'h2))
        else $error("valid outside read");
    AST_TWO: assert property ($fell(output_valid_flag)
        |-> halves == (loop_bypass_n ? 3'h7 : 3'h4))
        else $error("burst not two beats");
    AST_FOLLOW: assert property (k_rise
        |-> ##[1:4] $rose(echo_timing_out)) else $error("echo missing");
    AST_HALF: assert property ($rose(echo_timing_out)
        |-> echo_timing_out[*4]) else $error("echo pulse short");
    AST_EXCL: assert property (!(echo_timing_out
        && echo_timing_out_inv)) else $error("echo pair overlap");
    AST_OE: assert property (output_valid_flag
        == !shared_io_lines_oe_n) else $error("valid and drive differ");
    COV_RD: cover property (issue && read_select);
    COV_WR: cover property (issue && !read_select);
    COV_VALID: cover property ($rose(output_valid_flag));
endmodule // dbs_sram_sva
bind dbs_sram dbs_sram_sva dbs_sram_sva_inst (.*);

/* File: dbs_ctrl_model.sv */
// Controller model: link clocks, commands, write beats, read capture.
// Assumes the bench core clock; every change lands on its rising edge.
module dbs_ctrl_model import dbs_pkg::*; (
    // Core clock and memory outputs
    input  wire logic        core_clk, echo_timing_out, echo_timing_out_inv,
    input  wire logic        output_valid_flag,
    input  wire logic [17:0] shared_io_lines_out,
    // Link side and captured beats
    output logic             in_clk, in_clk_inv, operation_select_n,
    output logic             read_select,
    output logic [7:0]       word_location_inputs,
    output logic [1:0]       lane_write_mask_n,
    output logic [17:0]      drive_data, beat_lo, beat_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] eq;
    // Clocks stand still between frames, true low and complement high
    initial begin
        {in_clk, in_clk_inv, operation_select_n, read_select} = 4'h6;
        {word_location_inputs, lane_write_mask_n, drive_data} = 28'h0;
    end
    // A beat is taken two edges after its echo rises, once settled
    always @(posedge core_clk) begin
        eq <= {eq[1:0], echo_timing_out_inv, echo_timing_out};
        if (output_valid_flag && eq[1] && !eq[3])
            beat_lo <= shared_io_lines_out;
        if (output_valid_flag && eq[0] && !eq[2])
            beat_hi <= shared_io_lines_out;
    end
    // One link period of 16 core cycles; unused data lines toggle
    task automatic kcycle(input logic s, r, input logic [7:0] a,
                          input logic [1:0] m0, m1, input logic [17:0] d0, d1);
        {operation_select_n, read_select} <= {s, r};
        word_location_inputs <= a;
        lane_write_mask_n <= m0;
        drive_data <= (m0 == 2'h3) ? ~drive_data : d0;
        repeat (2) @(posedge core_clk);
        {in_clk, in_clk_inv} <= 2'h2;
        repeat (6) @(posedge core_clk);
        {operation_select_n, word_location_inputs} <= {1'b1, ~a};
        lane_write_mask_n <= m1;
        drive_data <= (m1 == 2'h3) ? ~drive_data : d1;
        repeat (2) @(posedge core_clk);
        {in_clk, in_clk_inv} <= 2'h1;
        repeat (6) @(posedge core_clk);
    endtask
endmodule // dbs_ctrl_model

/* File: tb_dbs_sram.sv */
// Bench: plain, masked and coherent write and read bursts.
// Assumes the controller model launches every link edge on core_clk.
module tb_dbs_sram;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        in_clk, in_clk_inv, operation_select_n, read_select;
    logic        shared_io_lines_oe_n, echo_timing_out, echo_timing_out_inv;
    logic        output_valid_flag;
    logic        loop_bypass_n = 1'b1;
    logic [7:0]  word_location_inputs;
    logic [1:0]  lane_write_mask_n;
    logic [17:0] drive_data, shared_io_lines_out, beat_lo, beat_hi;
    int          bad_count = 0;
    int          checks_done = 0;
    // Shared lines: the memory wins while it drives
    wire  [17:0] io_in = shared_io_lines_oe_n ? drive_data : shared_io_lines_out;
    always #4 core_clk = ~core_clk;
    dbs_sram dbs_sram_inst (.*, .shared_io_lines_in(io_in));
    dbs_ctrl_model dbs_ctrl_model_inst (.*);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t beat %h expected %h", $time, got, exp);
        end
    endtask
    task automatic kc(input logic s, r, input logic [7:0] a,
                      input logic [1:0] m0, m1, input logic [17:0] d0, d1);
        dbs_ctrl_model_inst.kcycle(s, r, a, m0, m1, d0, d1);
    endtask
    // Idle periods, then a bounded wait for the valid flag to drop
    task automatic tail();
        int i;
        repeat (4) kc(1'b1, 1'b0, 8'hA5, 2'h3, 2'h3, 18'h0, 18'h0);
        for (i = 0; i < 64 && output_valid_flag !== 1'b0; i++)
            @(posedge core_clk);
        if (i == 64) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [1:0] m0, m1,
                         input logic [17:0] d0, d1, e0, e1);
        kc(1'b0, 1'b0, a, 2'h3, 2'h3, 18'h0, 18'h0);
        kc(1'b1, 1'b0, 8'hA5, m0, m1, d0, d1);
        kc(1'b0, 1'b1, a, 2'h3, 2'h3, 18'h0, 18'h0);
        tail();
        chk(beat_lo, e0);
        chk(beat_hi, e1);
    endtask
    // Read on the first write-beat edge must see the buffered bytes
    task automatic t_coherent();
        kc(1'b0, 1'b0, 8'h44, 2'h3, 2'h3, 18'h0, 18'h0);
        kc(1'b0, 1'b1, 8'h44, 2'h0, 2'h0, 18'h12345, 18'h2ABCD);
        tail();
        chk(beat_lo, 18'h12345);
        chk(beat_hi, 18'h2ABCD);
    endtask
    // Loop bypassed: beat0 comes on a true edge, beat1 on the complement,
    // so the model's echo-keyed captures hold them swapped
    task automatic t_bypass();
        loop_bypass_n <= 1'b0;
        kc(1'b1, 1'b0, 8'hA5, 2'h3, 2'h3, 18'h0, 18'h0);
        kc(1'b0, 1'b0, 8'h30, 2'h3, 2'h3, 18'h0, 18'h0);
        kc(1'b1, 1'b0, 8'hA5, 2'h0, 2'h0, 18'h15555, 18'h0AAAA);
        kc(1'b0, 1'b1, 8'h30, 2'h3, 2'h3, 18'h0, 18'h0);
        tail();
        chk(beat_hi, 18'h15555);
        chk(beat_lo, 18'h0AAAA);
        loop_bypass_n <= 1'b1;
        kc(1'b1, 1'b0, 8'hA5, 2'h3, 2'h3, 18'h0, 18'h0);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wr_rd(8'h21, 2'h0, 2'h0, 18'h1A5A5, 18'h0C3C3, 18'h1A5A5, 18'h0C3C3);
        wr_rd(8'h21, 2'h2, 2'h1, 18'h3FFFF, 18'h3FFFF, 18'h1A5FF, 18'h3FFC3);
        t_coherent();
        t_bypass();
        complete_run();
    end
endmodule // tb_dbs_sram
